// ===== hdl/ts_pkg.sv
package ts_pkg;

    // clock and line rates, in kHz, for the fractional bit-rate generator
    localparam int          TS_CLK_KHZ      = 10000;
    localparam int          TS_LINE_KHZ     = 1544;

    // frame geometry
    localparam int          TS_CHANNELS     = 24;
    localparam int          TS_CHAN_BITS    = 8;
    localparam logic [7:0]  TS_LAST_POS     = 8'hc0;   // 193 positions, 0 is the framing bit
    localparam logic [7:0]  TS_FBIT_POS     = 8'h00;
    localparam logic [2:0]  TS_CHAN_FIRST   = 3'h1;    // pos[2:0] of each channel's first bit
    localparam logic [4:0]  TS_EXT_FRAMES   = 5'h18;   // extended superframe length
    localparam logic [4:0]  TS_BASIC_FRAMES = 5'h0c;   // basic multiframe length

    // framing patterns, first bit in the msb
    localparam logic [5:0]  TS_FAS_PATTERN  = 6'h0b;   // 001011
    localparam logic [5:0]  TS_FT_PATTERN   = 6'h2a;   // 101010, odd frames, basic
    localparam logic [5:0]  TS_FS_PATTERN   = 6'h0e;   // 001110, even frames, basic

    // signalling frames (1-based)
    localparam logic [4:0]  TS_SIG_A_FRAME  = 5'h06;
    localparam logic [4:0]  TS_SIG_B_FRAME  = 5'h0c;
    localparam logic [4:0]  TS_SIG_C_FRAME  = 5'h12;
    localparam logic [4:0]  TS_SIG_D_FRAME  = 5'h18;

    // crc-6 generator x^6 + x + 1, low terms
    localparam logic [5:0]  TS_CRC_POLY     = 6'h03;
    localparam logic [5:0]  TS_CRC_INIT     = 6'h00;

    // byte sent when the channel source has nothing ready
    localparam logic [7:0]  TS_IDLE_BYTE    = 8'hff;

    typedef struct packed {
        logic       sig_a;
        logic       sig_b;
        logic       sig_c;
        logic       sig_d;
        logic [7:0] data;
    } ts_chan_t;

    typedef struct packed {
        logic bit_val;
        logic strobe;
        logic b8zs;
    } ts_line_t;

endpackage : ts_pkg

// ===== hdl/ts_timing.sv
`timescale 1ns/10ps
// modulo-193 bit counter and frame counter; both advance only on a line-bit tick
module ts_timing
    import ts_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic       rst_b_in,
    input  wire logic       tick_in,
    input  wire logic [4:0] frames_in,
    output logic      [7:0] pos_out,
    output logic      [4:0] frame_out
);

    ////////////////////////////////////////////////////////////////////////////
    // bit position, wraps after the 193rd state
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pos_out <= TS_FBIT_POS;
        end else if (tick_in) begin
            if (pos_out == TS_LAST_POS) begin
                pos_out <= TS_FBIT_POS;
            end else begin
                pos_out <= pos_out + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame counter; the >= compare also recovers if the length shrinks mid-way
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            frame_out <= 5'h00;
        end else if (tick_in && pos_out == TS_LAST_POS) begin
            if (frame_out >= frames_in - 5'h01) begin
                frame_out <= 5'h00;
            end else begin
                frame_out <= frame_out + 5'h01;
            end
        end
    end

endmodule : ts_timing

// ===== hdl/ts_crc6.sv
`timescale 1ns/10ps
// serial crc-6 register, msb first; clear restarts it with the current bit
module ts_crc6
    import ts_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic       rst_b_in,
    input  wire logic       step_in,
    input  wire logic       clear_in,
    input  wire logic       bit_in,
    output logic      [5:0] crc_out
);

    logic [5:0] base;
    logic       feedback;

    // clear folds into the step so the boundary bit is not lost
    always_comb begin
        base     = clear_in ? TS_CRC_INIT : crc_out;
        feedback = base[5] ^ bit_in;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            crc_out <= TS_CRC_INIT;
        end else if (step_in) begin
            crc_out <= {base[4:0], 1'b0} ^ (feedback ? TS_CRC_POLY : 6'h00);
        end
    end

endmodule : ts_crc6

// ===== hdl/ts_framer.sv
`timescale 1ns/10ps
module ts_framer
    import ts_pkg::*;
#(
    parameter int CLK_KHZ  = TS_CLK_KHZ,
    parameter int LINE_KHZ = TS_LINE_KHZ
)(
    input  wire logic     clock_in,
    input  wire logic     rst_b_in,
    input  wire logic     ext_fmt_in,     // pin: 1 extended superframe, 0 basic
    input  wire logic     voice_in,       // pin: 1 robbed-bit signalling on
    input  wire ts_chan_t chan_in,        // channel byte with its signalling bits
    input  wire logic     chan_ack_in,    // chan_in valid, taken while chan_req_out
    input  wire logic     dl_bit_in,      // data-link bit
    input  wire logic     dl_ack_in,      // dl_bit_in valid, taken while dl_req_out
    output ts_line_t      line_out,       // bit, strobe and b8zs to the bipolar stage
    output logic          chan_req_out,
    output logic          dl_req_out,
    output logic          frame_sync_out, // pulse with the first bit of frame 1
    output logic    [4:0] frame_num_out   // 1-based frame number being sent
);

    localparam int ACC_W = $clog2(CLK_KHZ + LINE_KHZ + 1);

    // the tick generator can only serve a line slower than the clock
    generate
        if (LINE_KHZ <= 0 || LINE_KHZ >= CLK_KHZ) begin : g_bad_rate
            $error("ts_framer: line rate must be below the clock rate");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // framing bit for a 1-based frame number
    function automatic logic fbit_sel(input logic ext, input logic [4:0] fno,
                                      input logic dl, input logic [5:0] crc);
        logic [4:0] half;
        logic [4:0] quad;
        half = (fno - 5'h01) >> 1;
        quad = (fno - 5'h01) >> 2;
        if (ext) begin
            if (fno[0]) begin
                fbit_sel = dl;
            end else if (fno[1]) begin
                fbit_sel = crc[3'h5 - quad[2:0]];
            end else begin
                fbit_sel = TS_FAS_PATTERN[3'h5 - quad[2:0]];
            end
        end else if (fno[0]) begin
            fbit_sel = TS_FT_PATTERN[3'h5 - half[2:0]];
        end else begin
            fbit_sel = TS_FS_PATTERN[3'h5 - (half[2:0])];
        end
    endfunction : fbit_sel

    // robbed-bit substitution into the lsb
    function automatic logic [7:0] rob_sel(input logic ext, input logic voice,
                                           input logic [4:0] fno, input ts_chan_t ch);
        rob_sel = ch.data;
        if (voice) begin
            if (fno == TS_SIG_A_FRAME) begin
                rob_sel[0] = ch.sig_a;
            end else if (fno == TS_SIG_B_FRAME) begin
                rob_sel[0] = ch.sig_b;
            end else if (ext && fno == TS_SIG_C_FRAME) begin
                rob_sel[0] = ch.sig_c;
            end else if (ext && fno == TS_SIG_D_FRAME) begin
                rob_sel[0] = ch.sig_d;
            end
        end
    endfunction : rob_sel

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] next_acc;
    logic             tick;
    logic             ext_meta;
    logic             ext_fmt;
    logic             voice_meta;
    logic             voice;
    logic [7:0]       pos;
    logic [4:0]       frame;
    logic [4:0]       fno;
    logic             is_fbit;
    logic             chan_start;
    logic             sf_start;
    ts_chan_t         chan_buf;
    logic             buf_valid;
    logic             chan_take;
    logic             next_buf_valid;
    logic             dl_hold;
    logic             dl_valid;
    logic             dl_take;
    logic             dl_use;
    logic             next_dl_valid;
    logic [7:0]       shreg;
    logic [7:0]       load_byte;
    logic             next_bit;
    logic [5:0]       crc_run;
    logic [5:0]       crc_hold;

    ////////////////////////////////////////////////////////////////////////////
    // line-bit tick: fractional accumulator, one tick per line period on average
    always_comb begin
        next_acc = acc + ACC_W'(LINE_KHZ);
        if (next_acc >= ACC_W'(CLK_KHZ)) begin
            next_acc = next_acc - ACC_W'(CLK_KHZ);
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            acc  <= '0;
            tick <= 1'b0;
        end else begin
            acc  <= next_acc;
            tick <= (acc + ACC_W'(LINE_KHZ)) >= ACC_W'(CLK_KHZ);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode pins are asynchronous straps, two flops each
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ext_meta   <= 1'b0;
            ext_fmt    <= 1'b0;
            voice_meta <= 1'b0;
            voice      <= 1'b0;
        end else begin
            ext_meta   <= ext_fmt_in;
            ext_fmt    <= ext_meta;
            voice_meta <= voice_in;
            voice      <= voice_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timing counters
    ts_timing u_timing (
        .clock_in  (clock_in),
        .rst_b_in  (rst_b_in),
        .tick_in   (tick),
        .frames_in (ext_fmt ? TS_EXT_FRAMES : TS_BASIC_FRAMES),
        .pos_out   (pos),
        .frame_out (frame)
    );

    // position decode
    always_comb begin
        fno        = frame + 5'h01;
        is_fbit    = (pos == TS_FBIT_POS);
        chan_start = !is_fbit && (pos[2:0] == TS_CHAN_FIRST);
        sf_start   = is_fbit && (frame == 5'h00);
    end

    ////////////////////////////////////////////////////////////////////////////
    // channel input register with request/acknowledge
    always_comb begin
        chan_take      = chan_req_out && chan_ack_in;
        next_buf_valid = buf_valid;
        if (chan_take) begin
            next_buf_valid = 1'b1;
        end else if (tick && chan_start) begin
            next_buf_valid = 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            chan_buf     <= '0;
            buf_valid    <= 1'b0;
            chan_req_out <= 1'b0;
        end else begin
            if (chan_take) begin
                chan_buf <= chan_in;
            end
            buf_valid    <= next_buf_valid;
            chan_req_out <= !next_buf_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data-link register, same handshake; consumed by each extended odd frame
    always_comb begin
        dl_take       = dl_req_out && dl_ack_in;
        dl_use        = tick && is_fbit && ext_fmt && fno[0];
        next_dl_valid = dl_valid;
        if (dl_take) begin
            next_dl_valid = 1'b1;
        end else if (dl_use) begin
            next_dl_valid = 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dl_hold    <= 1'b1;
            dl_valid   <= 1'b0;
            dl_req_out <= 1'b0;
        end else begin
            if (dl_take) begin
                dl_hold <= dl_bit_in;
            end else if (dl_use) begin
                dl_hold <= 1'b1;  // an unserved link bit goes out as a mark
            end
            dl_valid   <= next_dl_valid;
            dl_req_out <= !next_dl_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bit-select multiplexer
    always_comb begin
        // an empty input register sends marks rather than zeros
        load_byte = rob_sel(ext_fmt, voice, fno,
                            buf_valid ? chan_buf : ts_chan_t'({4'hf, TS_IDLE_BYTE}));
        if (is_fbit) begin
            next_bit = fbit_sel(ext_fmt, fno, dl_hold, crc_hold);
        end else if (chan_start) begin
            next_bit = load_byte[7];
        end else begin
            next_bit = shreg[7];
        end
    end

    // data shift register; pauses over the framing bit
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            shreg <= 8'h00;
        end else if (tick && !is_fbit) begin
            shreg <= chan_start ? {load_byte[6:0], 1'b0} : {shreg[6:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // crc over everything sent in extended mode; value of the last superframe held for sending
    ts_crc6 u_crc (
        .clock_in (clock_in),
        .rst_b_in (rst_b_in),
        .step_in  (tick && ext_fmt),
        .clear_in (sf_start),
        .bit_in   (next_bit),
        .crc_out  (crc_run)
    );

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            crc_hold <= TS_CRC_INIT;
        end else if (tick && sf_start && ext_fmt) begin
            crc_hold <= crc_run;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered line outputs; each bit stands until the next tick
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            line_out <= '0;
        end else begin
            line_out.strobe <= tick;
            if (tick) begin
                line_out.bit_val <= next_bit;
                if (is_fbit) begin
                    line_out.b8zs <= 1'b0;
                end else if (chan_start) begin
                    line_out.b8zs <= (load_byte == 8'h00);
                end
            end
        end
    end

    // frame marker for downstream decoders
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            frame_sync_out <= 1'b0;
            frame_num_out  <= 5'h00;
        end else begin
            frame_sync_out <= tick && sf_start;
            if (tick && is_fbit) begin
                frame_num_out <= fno;
            end
        end
    end

endmodule : ts_framer

// ===== test/ts_framer_asserts.sv
`timescale 1ns/10ps
// port-level checks on the framer; sees only the top module's pins
module ts_framer_asserts
    import ts_pkg::*;
#(
    parameter int CLK_KHZ  = TS_CLK_KHZ,
    parameter int LINE_KHZ = TS_LINE_KHZ
)(
    input wire logic     clock_in,
    input wire logic     rst_b_in,
    input wire logic     ext_fmt_in,
    input wire logic     voice_in,
    input wire ts_chan_t chan_in,
    input wire logic     chan_ack_in,
    input wire logic     dl_bit_in,
    input wire logic     dl_ack_in,
    input wire ts_line_t line_out,
    input wire logic     chan_req_out,
    input wire logic     dl_req_out,
    input wire logic     frame_sync_out,
    input wire logic [4:0] frame_num_out
);
    logic [7:0] pos_h;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    //////////////////////////////////////////////////////////////////////////
    // line position of the bit shown with each strobe, 0 is the framing bit
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) pos_h <= 8'h00;
        else if (line_out.strobe) pos_h <= (pos_h == TS_LAST_POS) ? 8'h00 : pos_h + 8'h01;
    end

    //////////////////////////////////////////////////////////////////////////
    // gap bounds fit the default rates only: 10000/1544 gives 6 or 7 clocks
    sequence s_quiet;
        !line_out.strobe [*5];
    endsequence
    sequence s_fbit;
        line_out.strobe && pos_h == TS_FBIT_POS;
    endsequence
    property p_gap;
        line_out.strobe |=> s_quiet ##[1:2] line_out.strobe;
    endproperty
    property p_sync;
        frame_sync_out |-> s_fbit and frame_num_out == 5'h01;
    endproperty
    property p_fnum_at_f;
        $changed(frame_num_out) |-> s_fbit;
    endproperty
    property p_fnum_step;
        $changed(frame_num_out) |->
            frame_num_out == $past(frame_num_out) + 5'h01 || frame_num_out == 5'h01;
    endproperty
    property p_fnum_max;
        frame_num_out <= TS_EXT_FRAMES;
    endproperty
    property p_fnum_wrap;
        $changed(frame_num_out) && frame_num_out == 5'h01 && $past(frame_num_out) != 5'h00
            |-> $past(frame_num_out) == (ext_fmt_in ? TS_EXT_FRAMES : TS_BASIC_FRAMES);
    endproperty
    property p_b8_fbit;
        s_fbit |-> !line_out.b8zs;
    endproperty
    property p_b8_zero;
        line_out.strobe && line_out.b8zs |-> !line_out.bit_val;
    endproperty
    property p_b8_hold;
        line_out.strobe && pos_h[2:0] != TS_CHAN_FIRST && pos_h != TS_FBIT_POS
            |-> $stable(line_out.b8zs);
    endproperty
    property p_chan_hs;
        chan_req_out && chan_ack_in |=> !chan_req_out;
    endproperty
    property p_dl_hs;
        dl_req_out && dl_ack_in |=> !dl_req_out;
    endproperty

    a_gap:       assert property (p_gap) else $error("strobe spacing wrong");
    a_sync:      assert property (p_sync) else $error("frame sync misplaced");
    a_fnum_at_f: assert property (p_fnum_at_f) else $error("frame number moved off f bit");
    a_fnum_step: assert property (p_fnum_step) else $error("frame number skipped");
    a_fnum_max:  assert property (p_fnum_max) else $error("frame number too large");
    a_fnum_wrap: assert property (p_fnum_wrap) else $error("frame wrap length wrong");
    a_b8_fbit:   assert property (p_b8_fbit) else $error("b8zs high at f bit");
    a_b8_zero:   assert property (p_b8_zero) else $error("b8zs over a one bit");
    a_b8_hold:   assert property (p_b8_hold) else $error("b8zs changed inside byte");
    a_chan_hs:   assert property (p_chan_hs) else $error("channel request not dropped");
    a_dl_hs:     assert property (p_dl_hs) else $error("link request not dropped");
endmodule : ts_framer_asserts

bind ts_framer ts_framer_asserts #(
    .CLK_KHZ (CLK_KHZ),
    .LINE_KHZ(LINE_KHZ)
) u_chk (
    .clock_in      (clock_in),
    .rst_b_in      (rst_b_in),
    .ext_fmt_in    (ext_fmt_in),
    .voice_in      (voice_in),
    .chan_in       (chan_in),
    .chan_ack_in   (chan_ack_in),
    .dl_bit_in     (dl_bit_in),
    .dl_ack_in     (dl_ack_in),
    .line_out      (line_out),
    .chan_req_out  (chan_req_out),
    .dl_req_out    (dl_req_out),
    .frame_sync_out(frame_sync_out),
    .frame_num_out (frame_num_out)
);

// ===== test/ts_line_model.sv
`timescale 1ns/10ps
// bipolar stage: records every line bit and its b8zs flag, makes ami marks
module ts_line_model
    import ts_pkg::*;
(
    input  wire logic     clock_in,
    input  wire logic     rst_b_in,
    input  wire ts_line_t line_in,
    output logic          pos_out,
    output logic          neg_out
);
    logic bit_q[$];
    logic b8_q[$];
    logic mark_neg;

    // b8zs bytes go out as the violation pattern, not as ami; shown as space
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bit_q.delete();
            b8_q.delete();
            mark_neg <= 1'b0;
            pos_out  <= 1'b0;
            neg_out  <= 1'b0;
        end else if (line_in.strobe) begin
            bit_q.push_back(line_in.bit_val);
            b8_q.push_back(line_in.b8zs);
            pos_out <= line_in.bit_val && !line_in.b8zs && !mark_neg;
            neg_out <= line_in.bit_val && !line_in.b8zs && mark_neg;
            if (line_in.bit_val && !line_in.b8zs) mark_neg <= ~mark_neg;
        end
    end
endmodule : ts_line_model

// ===== test/test_t1_superframe_transmit_framer.sv
`timescale 1ns/10ps
module test_t1_superframe_transmit_framer
    import ts_pkg::*;
;
    logic       clock_in, rst_b_in, ext_fmt_in, voice_in;
    logic       chan_ack_in, dl_bit_in, dl_ack_in;
    logic       chan_req_out, dl_req_out, frame_sync_out, ami_pos, ami_neg;
    logic [4:0] frame_num_out;
    logic [5:0] crc_prev;
    ts_chan_t   chan_in;
    ts_line_t   line_out;
    ts_chan_t   sent_q[$];
    logic       dl_q[$];
    int         fails, cmp_count, chan_k, dl_k;
    bit         chan_en, dl_en;

    ts_framer u_dut (
        .clock_in      (clock_in),
        .rst_b_in      (rst_b_in),
        .ext_fmt_in    (ext_fmt_in),
        .voice_in      (voice_in),
        .chan_in       (chan_in),
        .chan_ack_in   (chan_ack_in),
        .dl_bit_in     (dl_bit_in),
        .dl_ack_in     (dl_ack_in),
        .line_out      (line_out),
        .chan_req_out  (chan_req_out),
        .dl_req_out    (dl_req_out),
        .frame_sync_out(frame_sync_out),
        .frame_num_out (frame_num_out)
    );

    ts_line_model u_line (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .line_in (line_out),
        .pos_out (ami_pos),
        .neg_out (ami_neg)
    );

    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    //////////////////////////////////////////////////////////////////////////
    // zero bytes every fifth channel; signalling bits differ per letter
    function automatic ts_chan_t mk_chan(input int k);
        logic [7:0] d;
        d = (k % 5 == 2) ? 8'h00 : 8'(k * 29 + 33);
        return '{~d[0], d[1], ~d[1], d[2], d};
    endfunction : mk_chan

    // sources answer each request at once; ack lasts one edge
    always @(negedge clock_in) begin
        if (!rst_b_in || chan_ack_in) chan_ack_in <= 1'b0;
        else if (chan_en && chan_req_out) begin
            chan_in <= mk_chan(chan_k);
            sent_q.push_back(mk_chan(chan_k));
            chan_k++;
            chan_ack_in <= 1'b1;
        end
        if (!rst_b_in || dl_ack_in) dl_ack_in <= 1'b0;
        else if (dl_en && dl_req_out) begin
            dl_bit_in <= 1'(dl_k ^ (dl_k >> 2));
            dl_q.push_back(1'(dl_k ^ (dl_k >> 2)));
            dl_k++;
            dl_ack_in <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s exp %b got %b", what, exp, got);
        end
    endtask : cmp_bit

    task automatic give_verdict;
        if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    task automatic wait_bits(input int n);
        while (u_line.bit_q.size() < n) @(posedge clock_in);
    endtask : wait_bits

    task automatic do_reset(input bit ext, input bit voice);
        @(negedge clock_in);
        rst_b_in = 1'b0;
        chan_en = 1'b0;
        dl_en = 1'b0;
        ext_fmt_in = ext;
        voice_in = voice;
        repeat (8) @(negedge clock_in);
        sent_q.delete();
        dl_q.delete();
        chan_k = 0;
        dl_k = 0;
        rst_b_in = 1'b1;
        repeat (2) @(negedge clock_in);
        chan_en = 1'b1;
    endtask : do_reset

    // msb-first crc over one 24-frame superframe as sent, x^6+x+1
    function automatic logic [5:0] crc_sf(input int g0);
        logic [5:0] r;
        logic fb;
        r = 6'h00;
        for (int i = g0 * 193; i < (g0 + 24) * 193; i++) begin
            fb = u_line.bit_q[i] ^ r[5];
            r = {r[4:0], 1'b0} ^ (fb ? TS_CRC_POLY : 6'h00);
        end
        return r;
    endfunction : crc_sf

    // walks captured frames; link bits are only fed from frame 24 on
    task automatic chk_range(input int g0, input int g1, input bit ext, input int vfrom);
        int f, b, n;
        logic fe;
        ts_chan_t c;
        logic [7:0] d;
        for (int g = g0; g < g1; g++) begin
            b = g * 193;
            f = ext ? g % 24 + 1 : g % 12 + 1;
            if (!ext) fe = (f % 2) ? TS_FT_PATTERN[5 - (f - 1) / 2] : TS_FS_PATTERN[6 - f / 2];
            else if (f % 2) fe = (g < 24) ? 1'b1 : dl_q[(g - 24) / 2];
            else if (f % 4 == 2) fe = (g < 24) ? 1'b0 : crc_prev[5 - (f - 2) / 4];
            else fe = TS_FAS_PATTERN[6 - f / 4];
            cmp_bit("framing bit", fe, u_line.bit_q[b]);
            for (int ch = 0; ch < 24; ch++) begin
                c = sent_q[g * 24 + ch];
                d = c.data;
                if (g >= vfrom && f == 6) d[0] = c.sig_a;
                if (g >= vfrom && f == 12) d[0] = c.sig_b;
                if (g >= vfrom && ext && f == 18) d[0] = c.sig_c;
                if (g >= vfrom && ext && f == 24) d[0] = c.sig_d;
                for (int i = 0; i < 8; i++) begin
                    n = b + 1 + ch * 8 + i;
                    cmp_bit("channel bit", d[7 - i], u_line.bit_q[n]);
                    cmp_bit("b8zs flag", d == 8'h00, u_line.b8_q[n]);
                end
            end
        end
    endtask : chk_range

    //////////////////////////////////////////////////////////////////////////
    task automatic t_basic;
        do_reset(1'b0, 1'b1);
        // one bit past the multiframe, so the 12 to 1 wrap is shown to the checker
        wait_bits(12 * 193 + 1);
        chk_range(0, 12, 1'b0, 0);
    endtask : t_basic

    // data traffic in the first superframe, voice in the second
    task automatic t_ext;
        do_reset(1'b1, 1'b0);
        wait_bits(23 * 193);
        dl_en = 1'b1;
        wait_bits(24 * 193 + 10);
        // pins move on the falling edge, away from the synchroniser's sample
        @(negedge clock_in);
        voice_in = 1'b1;
        wait_bits(48 * 193);
        crc_prev = crc_sf(0);
        chk_range(0, 48, 1'b1, 24);
    endtask : t_ext

    // source goes quiet: all 192 channel bits of a non-signalling frame must be ones
    task automatic t_under;
        int g;
        chan_en = 1'b0;
        g = u_line.bit_q.size() / 193 + 2;
        if (g % 6 == 5) g++;
        wait_bits((g + 1) * 193);
        for (int i = 1; i < 193; i++) begin
            cmp_bit("idle bit", 1'b1, u_line.bit_q[g * 193 + i]);
            cmp_bit("idle b8zs", 1'b0, u_line.b8_q[g * 193 + i]);
        end
    endtask : t_under

    initial begin
        rst_b_in = 1'b0;
        ext_fmt_in = 1'b0;
        voice_in = 1'b0;
        chan_in = '0;
        chan_ack_in = 1'b0;
        dl_bit_in = 1'b0;
        dl_ack_in = 1'b0;
        chan_en = 1'b0;
        dl_en = 1'b0;
        fails = 0;
        cmp_count = 0;
        chan_k = 0;
        dl_k = 0;
        t_basic();
        t_ext();
        t_under();
        give_verdict();
    end

    // about 65 frames of 1250 clocks are needed; this leaves some margin
    initial begin
        repeat (95000) @(posedge clock_in);
        fails++;
        give_verdict();
    end
endmodule : test_t1_superframe_transmit_framer
